//--- core/switch_global_lookup_config.sv
// Global lookup configuration registers and their per-frame decisions
`timescale 1ns/1ps
`default_nettype none

module switch_global_lookup_config (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Register access port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_q,
    output logic             reg_rvalid_q,
    // From neighbouring registers
    input  wire logic [31:0] mac_upper_bytes,
    input  wire logic [7:0]  age_period,
    input  wire logic        double_tag_en,
    input  wire logic        unknown_vid_fwd_en,
    // Frame length check
    input  wire logic        frame_check,
    input  wire logic [13:0] frame_payload_len,
    output logic             truncate_frame_q,
    // VLAN decisions
    input  wire logic        invalid_vid_seen,
    output logic             vid_drop_q,
    output logic             vid_to_host_q,
    output logic             vid_unknown_fwd_q,
    // Address table
    input  wire logic        entry_update,
    output logic      [2:0]  entry_age_q,
    output logic             entry_age_valid_q,
    input  wire logic        lookup_req,
    input  wire logic [47:0] dest_addr,
    output logic      [9:0]  lookup_index_q,
    output logic             lookup_index_valid_q,
    // Configuration outputs
    output logic      [15:0] default_tag_type_q,
    output logic      [15:0] outer_tag_type_q,
    output logic             vlan_enable_q,
    output logic             rsv_mcast_enable_q,
    output logic      [10:0] aging_time_q,
    output logic      [47:0] switch_mac_q
);

    // -------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------
    logic [7:0]  mac4_q, mac4_d;
    logic [7:0]  mac5_q, mac5_d;
    logic [15:0] mtu_q, mtu_d;
    logic [15:0] tpid_q, tpid_d;
    logic [7:0]  lkup0_q, lkup0_d;
    logic [7:0]  rdata_d;
    logic        rvalid_d;

    always_comb begin
        mac4_d   = mac4_q;
        mac5_d   = mac5_q;
        mtu_d    = mtu_q;
        tpid_d   = tpid_q;
        lkup0_d  = lkup0_q;
        rdata_d  = reg_rdata_q;
        rvalid_d = 1'b0;
        if (reg_wr) begin
            // All 16 bits stored and the low 14 compared, so 9000 fits without clamping
            unique case (reg_addr)
                switch_lookup_pkg::ADDR_MAC4:    mac4_d = reg_wdata;
                switch_lookup_pkg::ADDR_MAC5:    mac5_d = reg_wdata;
                switch_lookup_pkg::ADDR_MTU_HI:  mtu_d[15:8] = reg_wdata;
                switch_lookup_pkg::ADDR_MTU_LO:  mtu_d[7:0] = reg_wdata;
                switch_lookup_pkg::ADDR_TPID_HI: tpid_d[15:8] = reg_wdata;
                switch_lookup_pkg::ADDR_TPID_LO: tpid_d[7:0] = reg_wdata;
                switch_lookup_pkg::ADDR_LKUP0:   lkup0_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            rvalid_d = 1'b1;
            unique case (reg_addr)
                switch_lookup_pkg::ADDR_MAC4:    rdata_d = mac4_q;
                switch_lookup_pkg::ADDR_MAC5:    rdata_d = mac5_q;
                switch_lookup_pkg::ADDR_MTU_HI:  rdata_d = mtu_q[15:8];
                switch_lookup_pkg::ADDR_MTU_LO:  rdata_d = mtu_q[7:0];
                switch_lookup_pkg::ADDR_TPID_HI: rdata_d = tpid_q[15:8];
                switch_lookup_pkg::ADDR_TPID_LO: rdata_d = tpid_q[7:0];
                switch_lookup_pkg::ADDR_LKUP0:   rdata_d = lkup0_q;
                default:                         rdata_d = switch_lookup_pkg::RD_NONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mac4_q       <= switch_lookup_pkg::RST_MAC4;
            mac5_q       <= switch_lookup_pkg::RST_MAC5;
            mtu_q        <= switch_lookup_pkg::RST_MTU;
            tpid_q       <= switch_lookup_pkg::RST_TPID;
            lkup0_q      <= switch_lookup_pkg::RST_LKUP0;
            reg_rdata_q  <= switch_lookup_pkg::RD_NONE;
            reg_rvalid_q <= 1'b0;
        end else if (ce) begin
            mac4_q       <= mac4_d;
            mac5_q       <= mac5_d;
            mtu_q        <= mtu_d;
            tpid_q       <= tpid_d;
            lkup0_q      <= lkup0_d;
            reg_rdata_q  <= rdata_d;
            reg_rvalid_q <= rvalid_d;
        end
    end

    // -------------------------------------------------------------------
    // Decisions and configuration outputs
    // -------------------------------------------------------------------
    logic [2:0]  age_count;
    logic [1:0]  hash_sel;
    logic [9:0]  hash_index;
    logic        truncate_d, vdrop_d, vhost_d, vunk_d, age_valid_d, idx_valid_d;
    logic [2:0]  entry_age_d;
    logic [9:0]  index_d;
    logic [15:0] def_tag_d, outer_tag_d;
    logic [10:0] aging_d;
    logic [47:0] mac_d;

    assign age_count = lkup0_q[switch_lookup_pkg::AGE_MSB:switch_lookup_pkg::AGE_LSB];
    assign hash_sel  = lkup0_q[switch_lookup_pkg::HASH_MSB:switch_lookup_pkg::HASH_LSB];

    lookup_hash_index u_hash (
        .lookup_hash_select (hash_sel),
        .dest_addr          (dest_addr),
        .index              (hash_index)
    );

    always_comb begin
        truncate_d  = truncate_frame_q;
        if (frame_check) begin
            truncate_d = frame_payload_len > mtu_q[switch_lookup_pkg::MTU_LEN_W-1:0];
        end
        // Unknown-VID handling wins over the drop bit
        vunk_d  = invalid_vid_seen & unknown_vid_fwd_en;
        vdrop_d = invalid_vid_seen & ~unknown_vid_fwd_en & lkup0_q[switch_lookup_pkg::BIT_DROP_VID];
        vhost_d = invalid_vid_seen & ~unknown_vid_fwd_en & ~lkup0_q[switch_lookup_pkg::BIT_DROP_VID];
        age_valid_d = entry_update;
        entry_age_d = entry_update ? age_count : entry_age_q;
        idx_valid_d = lookup_req;
        index_d     = lookup_req ? hash_index : lookup_index_q;
        def_tag_d   = tpid_q;
        outer_tag_d = double_tag_en ? tpid_q : 16'h0000;
        // Largest product 7 x 255 still fits eleven bits
        aging_d     = 11'(age_count) * 11'(age_period);
        mac_d       = {mac_upper_bytes, mac4_q, mac5_q};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            truncate_frame_q     <= 1'b0;
            vid_drop_q           <= 1'b0;
            vid_to_host_q        <= 1'b0;
            vid_unknown_fwd_q    <= 1'b0;
            entry_age_q          <= 3'h0;
            entry_age_valid_q    <= 1'b0;
            lookup_index_q       <= 10'h000;
            lookup_index_valid_q <= 1'b0;
            default_tag_type_q   <= switch_lookup_pkg::RST_TPID;
            outer_tag_type_q     <= 16'h0000;
            vlan_enable_q        <= 1'b0;
            rsv_mcast_enable_q   <= 1'b0;
            aging_time_q         <= 11'h000;
            switch_mac_q         <= 48'h0;
        end else if (ce) begin
            truncate_frame_q     <= truncate_d;
            vid_drop_q           <= vdrop_d;
            vid_to_host_q        <= vhost_d;
            vid_unknown_fwd_q    <= vunk_d;
            entry_age_q          <= entry_age_d;
            entry_age_valid_q    <= age_valid_d;
            lookup_index_q       <= index_d;
            lookup_index_valid_q <= idx_valid_d;
            default_tag_type_q   <= def_tag_d;
            outer_tag_type_q     <= outer_tag_d;
            vlan_enable_q        <= lkup0_q[switch_lookup_pkg::BIT_VLAN_EN];
            rsv_mcast_enable_q   <= lkup0_q[switch_lookup_pkg::BIT_RSV_MC];
            aging_time_q         <= aging_d;
            switch_mac_q         <= mac_d;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    chk_truncate_flag: assert property (@(posedge clk) disable iff (!nrst)
        ce && frame_check |=> truncate_frame_q == ($past(frame_payload_len) > $past(mtu_q[13:0])))
        else $error("truncate flag wrong");
    chk_mtu_low_write: assert property (@(posedge clk) disable iff (!nrst)
        ce && reg_wr && reg_addr == switch_lookup_pkg::ADDR_MTU_LO |=> mtu_q[7:0] == $past(reg_wdata))
        else $error("limit low byte not stored");
    chk_byte_order: assert property (@(posedge clk) disable iff (!nrst)
        ce && reg_rd && reg_addr == switch_lookup_pkg::ADDR_TPID_HI |=> reg_rvalid_q && reg_rdata_q == $past(tpid_q[15:8]))
        else $error("high byte not at lower address");
    chk_outer_tag: assert property (@(posedge clk) disable iff (!nrst)
        ce && double_tag_en |=> outer_tag_type_q == $past(tpid_q) && default_tag_type_q == $past(tpid_q))
        else $error("tag type not driven");
    // Sampled reset in the antecedent skips the release edge, where flops were still in reset
    chk_vlan_enable: assert property (@(posedge clk) disable iff (!nrst)
        nrst && ce |=> vlan_enable_q == $past(lkup0_q[7]))
        else $error("vlan enable mismatch");
    chk_vid_drop: assert property (@(posedge clk) disable iff (!nrst)
        ce && invalid_vid_seen && !unknown_vid_fwd_en |=> vid_drop_q == $past(lkup0_q[6]) && vid_to_host_q != vid_drop_q)
        else $error("invalid vid policy wrong");
    chk_vid_override: assert property (@(posedge clk) disable iff (!nrst)
        ce && invalid_vid_seen && unknown_vid_fwd_en |=> vid_unknown_fwd_q && !vid_drop_q && !vid_to_host_q)
        else $error("unknown vid did not win");
    chk_age_write: assert property (@(posedge clk) disable iff (!nrst)
        ce && entry_update |=> entry_age_valid_q && entry_age_q == $past(lkup0_q[5:3]))
        else $error("age count not written");
    chk_aging_time: assert property (@(posedge clk) disable iff (!nrst)
        nrst && ce |=> aging_time_q == 11'($past(lkup0_q[5:3])) * 11'($past(age_period)))
        else $error("aging time wrong");
    chk_rsv_mcast: assert property (@(posedge clk) disable iff (!nrst)
        nrst && ce |=> rsv_mcast_enable_q == $past(lkup0_q[2]))
        else $error("reserved multicast enable wrong");
    chk_direct_index: assert property (@(posedge clk) disable iff (!nrst)
        ce && lookup_req && (lkup0_q[1:0] == 2'h0 || lkup0_q[1:0] == 2'h3)
        |=> lookup_index_valid_q && lookup_index_q == $past(dest_addr[9:0]))
        else $error("direct index wrong");
    chk_mac_addr: assert property (@(posedge clk) disable iff (!nrst)
        nrst && ce |=> switch_mac_q == {$past(mac_upper_bytes), $past(mac4_q), $past(mac5_q)})
        else $error("switch address mismatch");

endmodule

`default_nettype wire

//--- core/switch_lookup_pkg.sv
// Constants for the global lookup configuration register bank
package switch_lookup_pkg;

    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [15:0] ADDR_MAC4    = 16'h0306;
    localparam logic [15:0] ADDR_MAC5    = 16'h0307;
    localparam logic [15:0] ADDR_MTU_HI  = 16'h0308;
    localparam logic [15:0] ADDR_MTU_LO  = 16'h0309;
    localparam logic [15:0] ADDR_TPID_HI = 16'h030A;
    localparam logic [15:0] ADDR_TPID_LO = 16'h030B;
    localparam logic [15:0] ADDR_LKUP0   = 16'h0310;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0]  RST_MAC4  = 8'hFF;
    localparam logic [7:0]  RST_MAC5  = 8'hFF;
    localparam logic [15:0] RST_MTU   = 16'h07D0;
    localparam logic [15:0] RST_TPID  = 16'h9100;
    localparam logic [7:0]  RST_LKUP0 = 8'h61;
    localparam logic [7:0]  RD_NONE   = 8'h00;

    // -------------------------------------------------------------------
    // Field layout
    // -------------------------------------------------------------------
    localparam int unsigned MTU_LEN_W   = 14;
    localparam logic [13:0] MTU_JUMBO   = 14'h2328;
    localparam int unsigned BIT_VLAN_EN = 7;
    localparam int unsigned BIT_DROP_VID = 6;
    localparam int unsigned AGE_MSB     = 5;
    localparam int unsigned AGE_LSB     = 3;
    localparam int unsigned AGE_W       = 3;
    localparam int unsigned BIT_RSV_MC  = 2;
    localparam int unsigned HASH_MSB    = 1;
    localparam int unsigned HASH_LSB    = 0;
    localparam int unsigned PERIOD_W    = 8;
    localparam int unsigned AGING_W     = 11;

    // -------------------------------------------------------------------
    // Hash mapping
    // -------------------------------------------------------------------
    localparam logic [1:0]  HASH_DIRECT0 = 2'h0;
    localparam logic [1:0]  HASH_CRC     = 2'h1;
    localparam logic [1:0]  HASH_XOR     = 2'h2;
    localparam logic [1:0]  HASH_DIRECT3 = 2'h3;
    localparam int unsigned DA_W         = 48;
    localparam int unsigned INDEX_W      = 10;
    localparam logic [9:0]  CRC_POLY     = 10'h233;

endpackage

//--- core/lookup_hash_index.sv
// Dynamic table index from destination address, per hash select
`timescale 1ns/1ps
`default_nettype none

module lookup_hash_index (
    // Select and address
    input  wire logic [1:0]  lookup_hash_select,
    input  wire logic [47:0] dest_addr,
    // Table index
    output logic      [9:0]  index
);

    // -------------------------------------------------------------------
    // Hash functions
    // -------------------------------------------------------------------
    function automatic logic [9:0] crc_hash(input logic [47:0] a);
        logic [9:0] c;
        logic       fb;
        c = '0;
        for (int i = 47; i >= 0; i--) begin
            fb = c[9] ^ a[i];
            c  = {c[8:0], 1'b0} ^ (fb ? switch_lookup_pkg::CRC_POLY : 10'h000);
        end
        return c;
    endfunction

    function automatic logic [9:0] xor_hash(input logic [47:0] a);
        logic [9:0] x;
        x = a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30] ^ {2'h0, a[47:40]};
        return x;
    endfunction

    always_comb begin
        unique case (lookup_hash_select)
            switch_lookup_pkg::HASH_CRC: index = crc_hash(dest_addr);
            switch_lookup_pkg::HASH_XOR: index = xor_hash(dest_addr);
            switch_lookup_pkg::HASH_DIRECT0,
            switch_lookup_pkg::HASH_DIRECT3: index = dest_addr[9:0];
        endcase
    end

endmodule

`default_nettype wire

//--- sim/switch_global_lookup_config_tb.sv
// Self-checking bench for the global lookup configuration register bank
`timescale 1ns/1ps
`default_nettype none

module switch_global_lookup_config_tb;
    // ---------------------------------------------------------------
    // Signals, shadow registers and expectation queues
    // ---------------------------------------------------------------
    logic        clk, nrst, ce, reg_wr, reg_rd, double_tag_en, unknown_vid_fwd_en, fc_d;
    logic        frame_check, invalid_vid_seen, entry_update, lookup_req, reg_rvalid_q;
    logic        truncate_frame_q, vid_drop_q, vid_to_host_q, vid_unknown_fwd_q;
    logic        entry_age_valid_q, lookup_index_valid_q, vlan_enable_q, rsv_mcast_enable_q;
    logic [15:0] reg_addr, default_tag_type_q, outer_tag_type_q, max_frame_length, tpid;
    logic [7:0]  reg_wdata, age_period, reg_rdata_q, mac4, mac5, ctl;
    logic [31:0] mac_upper_bytes;
    logic [13:0] frame_payload_len;
    logic [47:0] dest_addr, switch_mac_q;
    logic [2:0]  entry_age_q;
    logic [9:0]  lookup_index_q;
    logic [10:0] aging_time_q;
    logic [7:0]  q_rd[$];
    logic [2:0]  q_vid[$], q_age[$];
    logic [9:0]  q_idx[$];
    logic        q_tr[$];
    int          failures, samples_checked;
    localparam logic [15:0] ADDRS[8] = '{16'h0306, 16'h0307, 16'h0308, 16'h0309, 16'h030A, 16'h030B,
                                         16'h0310, 16'h030C};

    switch_global_lookup_config u_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .mac_upper_bytes(mac_upper_bytes), .age_period(age_period), .double_tag_en(double_tag_en),
        .unknown_vid_fwd_en(unknown_vid_fwd_en), .frame_check(frame_check),
        .frame_payload_len(frame_payload_len), .truncate_frame_q(truncate_frame_q),
        .invalid_vid_seen(invalid_vid_seen), .vid_drop_q(vid_drop_q), .vid_to_host_q(vid_to_host_q),
        .vid_unknown_fwd_q(vid_unknown_fwd_q), .entry_update(entry_update), .entry_age_q(entry_age_q),
        .entry_age_valid_q(entry_age_valid_q), .lookup_req(lookup_req), .dest_addr(dest_addr),
        .lookup_index_q(lookup_index_q), .lookup_index_valid_q(lookup_index_valid_q),
        .default_tag_type_q(default_tag_type_q), .outer_tag_type_q(outer_tag_type_q),
        .vlan_enable_q(vlan_enable_q), .rsv_mcast_enable_q(rsv_mcast_enable_q),
        .aging_time_q(aging_time_q), .switch_mac_q(switch_mac_q));

    // ---------------------------------------------------------------
    // Compare tasks and reference functions
    // ---------------------------------------------------------------
    task automatic tally(input bit ok, input string what);
        samples_checked++;
        if (!ok) begin
            failures++;
            $display("Error at %0t: %s mismatch", $time, what);
        end
    endtask
    task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
        tally(g === e, "read data");
    endtask
    task automatic cmp_vid(input logic [2:0] g, input logic [2:0] e);
        tally(g === e, "vid decision");
    endtask
    task automatic cmp_age(input logic [2:0] g, input logic [2:0] e);
        tally(g === e, "entry age");
    endtask
    task automatic cmp_idx(input logic [9:0] g, input logic [9:0] e);
        tally(g === e, "lookup index");
    endtask
    task automatic cmp_tr(input logic g, input logic e);
        tally(g === e, "truncate");
    endtask
    task automatic cmp_cfg(input logic [47:0] g, input logic [47:0] e);
        tally(g === e, "config output");
    endtask

    // Independent bitwise reference, MSB first, zero start
    function automatic logic [9:0] exp_idx(input logic [1:0] s, input logic [47:0] d);
        logic [9:0] c;
        c = 10'h000;
        for (int i = 47; i >= 0; i--) begin
            c = {c[8:0], 1'b0} ^ ((c[9] ^ d[i]) ? switch_lookup_pkg::CRC_POLY : 10'h000);
        end
        if (s == 2'h1) return c;
        if (s == 2'h2) return d[9:0] ^ d[19:10] ^ d[29:20] ^ d[39:30] ^ {2'h0, d[47:40]};
        return d[9:0];
    endfunction

    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        case (a)
            16'h0306: return mac4;
            16'h0307: return mac5;
            16'h0308: return max_frame_length[15:8];
            16'h0309: return max_frame_length[7:0];
            16'h030A: return tpid[15:8];
            16'h030B: return tpid[7:0];
            16'h0310: return ctl;
            default:  return 8'h00;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        case (a)
            16'h0306: mac4 = d;
            16'h0307: mac5 = d;
            16'h0308: max_frame_length[15:8] = d;
            16'h0309: max_frame_length[7:0] = d;
            16'h030A: tpid[15:8] = d;
            16'h030B: tpid[7:0] = d;
            16'h0310: ctl = d;
            default: ;
        endcase
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        q_rd.push_back(exp_rd(a));
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic chk_len(input logic [13:0] len);
        @(posedge clk);
        frame_check       <= 1'b1;
        frame_payload_len <= len;
        q_tr.push_back(len > max_frame_length[13:0]);
        @(posedge clk);
        frame_check <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Monitor: settled outputs are checked on the falling edge
    // ---------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) fc_d <= 1'b0;
        else fc_d <= frame_check & ce;
    end
    always @(negedge clk) begin
        if (reg_rvalid_q === 1'b1) cmp_rd(reg_rdata_q, q_rd.pop_front());
        if ({vid_drop_q, vid_to_host_q, vid_unknown_fwd_q} !== 3'h0)
            cmp_vid({vid_drop_q, vid_to_host_q, vid_unknown_fwd_q}, q_vid.pop_front());
        if (entry_age_valid_q === 1'b1) cmp_age(entry_age_q, q_age.pop_front());
        if (lookup_index_valid_q === 1'b1) cmp_idx(lookup_index_q, q_idx.pop_front());
        if (fc_d) cmp_tr(truncate_frame_q, q_tr.pop_front());
    end

    task automatic final_report;
        $display("Checked %0d results, %0d failures", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 4000);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {nrst, reg_wr, reg_rd, double_tag_en, unknown_vid_fwd_en} = 5'h00;
        {frame_check, invalid_vid_seen, entry_update, lookup_req} = 4'h0;
        {reg_addr, reg_wdata, frame_payload_len, dest_addr} = '0;
        ce = 1'b1;
        {mac4, mac5, max_frame_length, tpid, ctl} = {8'hFF, 8'hFF, 16'h07D0, 16'h9100, 8'h61};
        void'($urandom(32'hDBAE));
        mac_upper_bytes = $urandom();
        age_period = 8'($urandom());
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        foreach (ADDRS[i]) rd(ADDRS[i]);
        @(negedge clk);
        cmp_cfg(48'(default_tag_type_q), 48'h9100);
        cmp_cfg(48'({outer_tag_type_q, vlan_enable_q, rsv_mcast_enable_q}), 48'h0);
        cmp_cfg(48'(aging_time_q), 48'(age_period) * 48'h4);
        cmp_cfg(switch_mac_q, {mac_upper_bytes, 16'hFFFF});
        chk_len(14'd2000);
        chk_len(14'd2001);
        // Random contents, then the jumbo limit with reserved bits set
        mac_upper_bytes <= $urandom();
        for (int i = 0; i < 7; i++) wr(ADDRS[i], 8'($urandom()));
        wr(16'h0308, 8'hE3);
        wr(16'h0309, 8'h28);
        foreach (ADDRS[i]) rd(ADDRS[i]);
        chk_len(14'h2328);
        chk_len(14'h2329);
        @(negedge clk);
        cmp_cfg(48'({default_tag_type_q, outer_tag_type_q}), 48'({tpid, 16'h0}));
        cmp_cfg(switch_mac_q, {mac_upper_bytes, mac4, mac5});
        @(posedge clk);
        double_tag_en <= 1'b1;
        repeat (2) @(negedge clk);
        cmp_cfg(48'(outer_tag_type_q), 48'(tpid));
        // A write while the clock enable is low must be lost
        @(posedge clk);
        {ce, reg_wr, reg_addr, reg_wdata} <= {1'b0, 1'b1, 16'h0306, ~mac4};
        @(posedge clk);
        {ce, reg_wr} <= 2'b10;
        rd(16'h0306);
        for (int k = 0; k < 4; k++) begin
            wr(16'h0310, {ctl[7], k[0], ctl[5:0]});
            @(posedge clk);
            {unknown_vid_fwd_en, invalid_vid_seen} <= {k[1], 1'b1};
            q_vid.push_back(k[1] ? 3'h1 : (k[0] ? 3'h4 : 3'h2));
            @(posedge clk);
            invalid_vid_seen <= 1'b0;
        end
        for (int a = 0; a < 8; a++) begin
            wr(16'h0310, {ctl[7:6], 3'(a), ctl[2:0]});
            @(posedge clk);
            entry_update <= 1'b1;
            age_period   <= 8'($urandom());
            q_age.push_back(3'(a));
            @(posedge clk);
            entry_update <= 1'b0;
            @(negedge clk);
            cmp_cfg(48'(aging_time_q), 48'(age_period) * 48'(a));
        end
        for (int s = 0; s < 4; s++) begin
            // No table behind this block, so enabling VLAN mode here has nothing to set up first
            wr(16'h0310, {s[0], 1'b1, 3'h4, s[1], 2'(s)});
            repeat (2) @(posedge clk);
            @(negedge clk);
            cmp_cfg(48'({vlan_enable_q, rsv_mcast_enable_q}), 48'({s[0], s[1]}));
            @(posedge clk);
            for (int j = 0; j < 3; j++) begin
                lookup_req <= 1'b1;
                dest_addr  <= {$urandom(), $urandom()};
                @(posedge clk);
                q_idx.push_back(exp_idx(2'(s), dest_addr));
            end
            lookup_req <= 1'b0;
        end
        repeat (4) @(posedge clk);
        tally(q_rd.size() + q_vid.size() + q_age.size() + q_idx.size() + q_tr.size() == 0, "pending");
        final_report();
    end
endmodule

`default_nettype wire
